// ### fppc_cpu_model.sv
// processor-side model: fetch and data reads on the array read port
`timescale 1ns/1ps
module fppc_cpu_model (
  // clock
  input wire logic clk_sys,
  // array read port
  output logic rd_req,
  output logic rd_fetch,
  output logic [16:0] rd_addr,
  input wire logic [31:0] rd_data
);
  // idle lines at time zero
  initial begin
    rd_req = 1'b0;
    rd_fetch = 1'b0;
    rd_addr = 17'h0;
  end
  // one read: request for a cycle, capture after the answering edge
  task automatic access(input logic fetch, input logic [16:0] addr, output logic [31:0] d);
    @(posedge clk_sys);
    rd_req <= 1'b1;
    rd_fetch <= fetch;
    rd_addr <= addr;
    @(posedge clk_sys);
    rd_req <= 1'b0;
    rd_addr <= ~addr; // released lines do not keep the old address
    #1 d = rd_data;
  endtask
endmodule // fppc_cpu_model

// ### fppc_ctrl_checker.sv
// checker: port-level timing relations of the flash controller
`timescale 1ns/1ps
module fppc_ctrl_checker #(
  parameter int WORDS = 32768
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // outputs
  input wire logic [31:0] rd_data,
  input wire logic flash_irq,
  input wire logic busy
);
  logic [31:0] run_len;
  logic ctl_wr;
  // length of the current busy stretch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) run_len <= 32'h0;
    else if (busy) run_len <= run_len + 32'h1;
    else run_len <= 32'h0;
  end
  // write to the control register
  assign ctl_wr = reg_wr && reg_addr == fppc_pkg::OFS_CONTROL;

  a_key_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(busy) |-> $past(ctl_wr && reg_wdata[31:16] == fppc_pkg::WRITE_KEY))
    else $error("busy rose without a keyed control write");
  a_key_ignore: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_wr && reg_wdata[31:16] != fppc_pkg::WRITE_KEY && !busy |=> !busy)
    else $error("unkeyed control write started an operation");
  a_busy_min: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(busy) |-> busy [*8])
    else $error("operation dropped busy too early");
  a_pulse_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(busy) |-> run_len >= 32'd20)
    else $error("operation shorter than one timed pulse");
  a_busy_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run_len <= WORDS + 11000)
    else $error("operation never completed");
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_reset_quiet: assert property (@(posedge clk_sys)
    !rst_n |=> reg_rdata == 32'h0 && rd_data == 32'h0 && !busy)
    else $error("outputs not cleared by reset");
  a_irq_reset: assert property (@(posedge clk_sys)
    !rst_n |=> !flash_irq)
    else $error("interrupt high after reset");
endmodule // fppc_ctrl_checker

bind fppc_flash_ctrl fppc_ctrl_checker #(.WORDS(WORDS)) i_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rd_data(rd_data), .flash_irq(flash_irq),
  .busy(busy));

// ### fppc_flash_ctrl.sv
// flash controller: register file, protection policy, program/erase/commit sequencer
`timescale 1ns/1ps

// Overview of operation
// - page erase sets every word of one 1 KB page to all ones
// - word program ANDs data into one 32-bit word, only clearing bits
// - one program-enable and one read-enable bit per 2 KB region
// - program or erase of a region with program-enable zero is refused
// - read-enable zero allows only instruction fetch, data reads denied
// - read-only and execute-only regions both refuse program and erase
// - refused modify sets access-violation status, interrupt if its mask set
// - denied data read returns zero and may raise an interrupt
// - protection bits reset to all ones from the factory
// - uncommitted protection writes act at once but are lost at any reset
// - microsecond reload is clock MHz minus one, reset value suits fastest clock
// - program: load data, address, write key plus write bit; bit clears at end
// - erase: load page address, write key plus erase bit; bit clears at end
// - mass erase: write key plus mass bit; bit clears after whole array
// - nonvolatile registers stay untouched by page and mass erase
// - key plus commit bit stores selected register; bit stays set until done
// - address value selects which protection or user register is committed
// - debug config commits from the write data register at its selector
// - committing only clears bits, ones never return by user programming
// - bit 31 of user and debug registers shows writable; a commit that clears it locks the register
module fppc_flash_ctrl #(
  parameter int WORDS = 32768,
  parameter int REGIONS = 64
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic por_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // array read port
  input wire logic rd_req,
  input wire logic rd_fetch,
  input wire logic [16:0] rd_addr,
  output logic [31:0] rd_data,
  // interrupt and busy
  output logic flash_irq,
  output logic busy
);

  localparam int RW = REGIONS / 32;

  // array, volatile and committed protection, user words
  logic [31:0] mem [WORDS];
  logic [31:0] read_en [RW];
  logic [31:0] prog_en [RW];
  logic [31:0] read_en_nv [RW];
  logic [31:0] prog_en_nv [RW];
  logic [31:0] user_nv [2];
  logic [31:0] user_vol [2];
  logic [31:0] debug_nv;
  logic [31:0] target_addr;
  logic [31:0] write_data;
  logic [3:0] op_bits;
  logic [7:0] usec_reload;
  logic [2:0] raw_status;
  logic [2:0] int_mask;
  fppc_pkg::fppc_state_t state;
  logic [7:0] us_div;
  logic us_tick;
  logic [7:0] us_left;
  logic [14:0] sweep;
  logic [14:0] sweep_end;
  logic viol_ev;
  logic done_ev;
  logic rdviol_ev;
  logic ctl_wr;
  logic key_ok;

  // region permission lookup from a byte address
  // regions 0..31 sit in word 0 and regions 32..63 in word 1
  function automatic logic region_bit(input logic [31:0] vec [RW], input logic [16:0] a);
    logic [5:0] r;
    r = a[16:11];
    return vec[r[5:5]][r[4:0]];
  endfunction

  // a region is writable only when its program-enable bit is one
  function automatic logic may_modify(input logic [31:0] vec [RW], input logic [16:0] a);
    return region_bit(vec, a);
  endfunction

  // control decode; busy stays high for the whole life of an operation
  assign ctl_wr = reg_wr && (reg_addr == fppc_pkg::OFS_CONTROL);
  assign key_ok = (reg_wdata[31:16] == fppc_pkg::WRITE_KEY);
  assign busy = |op_bits;

  // microsecond tick: reload+1 cycles per microsecond
  // restarting the divider while idle makes every pulse begin on a whole microsecond
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state == fppc_pkg::FPPC_IDLE) begin
      us_div <= 8'h00;
      us_tick <= 1'b0;
    end else if (us_div == usec_reload) begin
      us_div <= 8'h00;
      us_tick <= 1'b1;
    end else begin
      us_div <= us_div + 8'h01;
      us_tick <= 1'b0;
    end
  end

  // plain registers written by software
  // the control word is not stored here: its operation bits live in the sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      target_addr <= 32'h0000_0000;
      write_data <= 32'h0000_0000;
      usec_reload <= fppc_pkg::USEC_RELOAD_RST;
      int_mask <= 3'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        fppc_pkg::OFS_TARGET_ADDR: target_addr <= reg_wdata;
        fppc_pkg::OFS_WRITE_DATA: write_data <= reg_wdata;
        fppc_pkg::OFS_USEC_RELOAD: usec_reload <= reg_wdata[7:0];
        fppc_pkg::OFS_INT_MASK: int_mask <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // volatile protection: reloaded from committed copy on reset
  // a plain reset therefore drops any trial value that was never committed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < RW; i++) begin
        read_en[i] <= read_en_nv[i];
        prog_en[i] <= prog_en_nv[i];
      end
    end else if (reg_wr) begin
      for (int i = 0; i < RW; i++) begin
        if (reg_addr == fppc_pkg::OFS_READ_EN_0 + 12'(4 * i)) begin
          read_en[i] <= reg_wdata;
        end
        if (reg_addr == fppc_pkg::OFS_PROG_EN_0 + 12'(4 * i)) begin
          prog_en[i] <= reg_wdata;
        end
      end
    end
  end

  // volatile user words: tried out before commit, reloaded from the stored copy on reset
  // a commit that clears the not-yet-written flag locks the word, and further writes are dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      user_vol[0] <= user_nv[0];
      user_vol[1] <= user_nv[1];
    end else if (reg_wr) begin
      if (reg_addr == fppc_pkg::OFS_USER_0 && user_nv[0][fppc_pkg::BIT_NOT_WRITTEN]) begin
        user_vol[0] <= reg_wdata;
      end
      if (reg_addr == fppc_pkg::OFS_USER_1 && user_nv[1][fppc_pkg::BIT_NOT_WRITTEN]) begin
        user_vol[1] <= reg_wdata;
      end
    end
  end

  // nonvolatile registers: set to factory values only by power-on, changed only by commit
  // each commit ANDs into the stored copy, so software can never bring a one back
  always_ff @(posedge clk_sys) begin
    if (!por_n) begin
      for (int i = 0; i < RW; i++) begin
        read_en_nv[i] <= fppc_pkg::ALL_ONES;
        prog_en_nv[i] <= fppc_pkg::ALL_ONES;
      end
      user_nv[0] <= fppc_pkg::ALL_ONES;
      user_nv[1] <= fppc_pkg::ALL_ONES;
      debug_nv <= fppc_pkg::DEBUG_RST;
    end else if (state == fppc_pkg::FPPC_FINISH && op_bits[fppc_pkg::BIT_COMMIT]) begin
      // erase never reaches here, so nv words survive it
      for (int i = 0; i < RW; i++) begin
        if (target_addr == 32'(2 * i)) begin
          read_en_nv[i] <= read_en_nv[i] & read_en[i];
        end
        if (target_addr == 32'(2 * i + 1)) begin
          prog_en_nv[i] <= prog_en_nv[i] & prog_en[i];
        end
      end
      for (int u = 0; u < 2; u++) begin
        if (target_addr == fppc_pkg::SEL_USER_0 + 32'(u)
            && user_nv[u][fppc_pkg::BIT_NOT_WRITTEN]) begin
          user_nv[u] <= user_nv[u] & user_vol[u];
        end
      end
      if (target_addr == fppc_pkg::SEL_DEBUG && debug_nv[fppc_pkg::BIT_NOT_WRITTEN]) begin
        debug_nv <= debug_nv & write_data;
      end
    end
  end

  // operation sequencer
  // a start while another operation runs is dropped without any status;
  // a refused modify reports only through the access-violation status;
  // commits skip the protection check so protection itself can be stored
  always_ff @(posedge clk_sys) begin
    viol_ev <= 1'b0;
    done_ev <= 1'b0;
    if (!rst_n) begin
      state <= fppc_pkg::FPPC_IDLE;
      op_bits <= 4'h0;
      us_left <= 8'h00;
      sweep <= 15'h0000;
      sweep_end <= 15'h0000;
    end else begin
      unique case (state)
        fppc_pkg::FPPC_IDLE: begin
          if (ctl_wr && key_ok && |reg_wdata[3:0]) begin
            if ((reg_wdata[fppc_pkg::BIT_WRITE] || reg_wdata[fppc_pkg::BIT_ERASE])
                && !may_modify(prog_en, target_addr[16:0])) begin
              viol_ev <= 1'b1;
            end else begin
              op_bits <= reg_wdata[3:0];
              state <= fppc_pkg::FPPC_PULSE;
              if (reg_wdata[fppc_pkg::BIT_ERASE]) begin
                us_left <= 8'(fppc_pkg::ERASE_US);
                sweep <= {target_addr[16:10], 8'h00};
                sweep_end <= {target_addr[16:10], 8'hff};
              end else if (reg_wdata[fppc_pkg::BIT_MASS]) begin
                us_left <= 8'(fppc_pkg::ERASE_US);
                sweep <= 15'h0000;
                sweep_end <= 15'(WORDS - 1);
              end else begin
                us_left <= 8'(fppc_pkg::PROGRAM_US);
                sweep <= target_addr[16:2];
                sweep_end <= target_addr[16:2];
              end
            end
          end
        end
        fppc_pkg::FPPC_PULSE: begin
          if (us_tick) begin
            us_left <= us_left - 8'h01;
            if (us_left == 8'h01) begin
              state <= fppc_pkg::FPPC_FINISH;
            end
          end
        end
        fppc_pkg::FPPC_FINISH: begin
          // erases sweep one word per cycle before the bit drops
          if (sweep == sweep_end || op_bits[fppc_pkg::BIT_COMMIT]) begin
            op_bits <= 4'h0;
            done_ev <= 1'b1;
            state <= fppc_pkg::FPPC_IDLE;
          end else begin
            sweep <= sweep + 15'h0001;
          end
        end
        default: state <= fppc_pkg::FPPC_IDLE;
      endcase
    end
  end

  // array updates
  // a program only clears bits, so two programs of one word merge both patterns
  always_ff @(posedge clk_sys) begin
    if (state == fppc_pkg::FPPC_FINISH) begin
      if (op_bits[fppc_pkg::BIT_WRITE]) begin
        mem[sweep] <= mem[sweep] & write_data;
      end else if (op_bits[fppc_pkg::BIT_ERASE] || op_bits[fppc_pkg::BIT_MASS]) begin
        mem[sweep] <= fppc_pkg::ALL_ONES;
      end
    end
  end

  // array read port, data reads of read-protected regions give zero
  // fetches bypass the read-enable policy so execute-only code still runs
  always_ff @(posedge clk_sys) begin
    rdviol_ev <= 1'b0;
    if (!rst_n) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_req) begin
      if (rd_fetch || region_bit(read_en, rd_addr)) begin
        rd_data <= mem[rd_addr[16:2]];
      end else begin
        rd_data <= 32'h0000_0000;
        rdviol_ev <= 1'b1;
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  // a clear in the cycle of a new event loses, so no event goes unseen
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      raw_status <= 3'h0;
    end else begin
      for (int b = 0; b < 3; b++) begin
        if ((b == fppc_pkg::BIT_ACCESS_VIOL && viol_ev)
            || (b == fppc_pkg::BIT_OP_DONE && done_ev)
            || (b == fppc_pkg::BIT_READ_VIOL && rdviol_ev)) begin
          raw_status[b] <= 1'b1;
        end else if (reg_wr && reg_addr == fppc_pkg::OFS_INT_CLEAR && reg_wdata[b]) begin
          raw_status[b] <= 1'b0;
        end
      end
    end
  end

  // interrupt line: any status bit whose mask bit is set
  assign flash_irq = |(raw_status & int_mask);

  // register read data, one cycle after the strobe
  // unmapped offsets read as zero; the user words show their volatile copies
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      unique case (reg_addr)
        fppc_pkg::OFS_TARGET_ADDR: reg_rdata <= target_addr;
        fppc_pkg::OFS_WRITE_DATA: reg_rdata <= write_data;
        fppc_pkg::OFS_CONTROL: reg_rdata <= {28'h0000000, op_bits};
        fppc_pkg::OFS_RAW_STATUS: reg_rdata <= {29'h0, raw_status};
        fppc_pkg::OFS_INT_MASK: reg_rdata <= {29'h0, int_mask};
        fppc_pkg::OFS_INT_CLEAR: reg_rdata <= {29'h0, raw_status & int_mask};
        fppc_pkg::OFS_USEC_RELOAD: reg_rdata <= {24'h000000, usec_reload};
        fppc_pkg::OFS_DEBUG_CFG: reg_rdata <= debug_nv;
        fppc_pkg::OFS_USER_0: reg_rdata <= user_vol[0];
        fppc_pkg::OFS_USER_1: reg_rdata <= user_vol[1];
        default: begin
          for (int i = 0; i < RW; i++) begin
            if (reg_addr == fppc_pkg::OFS_READ_EN_0 + 12'(4 * i)) begin
              reg_rdata <= read_en[i];
            end
            if (reg_addr == fppc_pkg::OFS_PROG_EN_0 + 12'(4 * i)) begin
              reg_rdata <= prog_en[i];
            end
          end
        end
      endcase
    end
  end

endmodule // fppc_flash_ctrl

// ### fppc_pkg.sv
// package: register offsets, control encodings, reset values and timing for the flash controller
package fppc_pkg;
  // register byte offsets on the plain register port
  localparam logic [11:0] OFS_TARGET_ADDR = 12'h000;
  localparam logic [11:0] OFS_WRITE_DATA = 12'h004;
  localparam logic [11:0] OFS_CONTROL = 12'h008;
  localparam logic [11:0] OFS_RAW_STATUS = 12'h00c;
  localparam logic [11:0] OFS_INT_MASK = 12'h010;
  localparam logic [11:0] OFS_INT_CLEAR = 12'h014;
  localparam logic [11:0] OFS_USEC_RELOAD = 12'h140;
  localparam logic [11:0] OFS_DEBUG_CFG = 12'h1d0;
  localparam logic [11:0] OFS_USER_0 = 12'h1e0;
  localparam logic [11:0] OFS_USER_1 = 12'h1e4;
  localparam logic [11:0] OFS_READ_EN_0 = 12'h200;
  localparam logic [11:0] OFS_PROG_EN_0 = 12'h400;
  // control word fields
  localparam logic [15:0] WRITE_KEY = 16'ha442;
  localparam int BIT_WRITE = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_COMMIT = 3;
  localparam int BIT_NOT_WRITTEN = 31;
  // interrupt status bits
  localparam int BIT_ACCESS_VIOL = 0;
  localparam int BIT_OP_DONE = 1;
  localparam int BIT_READ_VIOL = 2;
  // commit selectors held in the target address
  localparam logic [31:0] SEL_USER_0 = 32'h8000_0000;
  localparam logic [31:0] SEL_USER_1 = 32'h8000_0001;
  localparam logic [31:0] SEL_DEBUG = 32'h7510_0000;
  // reset values
  localparam logic [7:0] USEC_RELOAD_RST = 8'h31;
  localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
  localparam logic [31:0] DEBUG_RST = 32'hffff_fffe;
  // pulse lengths in microseconds
  localparam int PROGRAM_US = 20;
  localparam int ERASE_US = 40;
  localparam int COMMIT_US = 20;
  // geometry
  localparam int ADDR_W = 17;
  localparam int WORD_ADDR_W = 15;
  localparam int PAGE_WORDS = 256;

  // operation states, gray along idle-pulse-finish
  typedef enum logic [1:0] {
    FPPC_IDLE = 2'b00,
    FPPC_PULSE = 2'b01,
    FPPC_FINISH = 2'b11
  } fppc_state_t;

  // array port request
  typedef struct packed {
    logic wr;
    logic [14:0] idx;
    logic [31:0] data;
  } fppc_array_req_t;
endpackage

// ### tb_flash_program_protect_ctrl.sv
// testbench: program, erase, protection and commit sequences
`timescale 1ns/1ps
module tb_flash_program_protect_ctrl;
  logic clk_sys, rst_n, por_n, reg_wr, reg_rd, rd_req, rd_fetch, flash_irq, busy;
  logic [11:0] reg_addr;
  logic [16:0] rd_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_data, v;
  int errors, total_checks;
  localparam logic [11:0] A_CTL = fppc_pkg::OFS_CONTROL;
  localparam logic [11:0] A_TGT = fppc_pkg::OFS_TARGET_ADDR;
  localparam logic [11:0] A_DAT = fppc_pkg::OFS_WRITE_DATA;
  localparam logic [11:0] A_PE = fppc_pkg::OFS_PROG_EN_0;
  localparam logic [11:0] A_RE = fppc_pkg::OFS_READ_EN_0;
  localparam logic [11:0] A_U0 = fppc_pkg::OFS_USER_0;
  localparam logic [11:0] A_DBG = fppc_pkg::OFS_DEBUG_CFG;
  localparam logic [31:0] KEY = {fppc_pkg::WRITE_KEY, 16'h0};

  fppc_flash_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rd_req(rd_req), .rd_fetch(rd_fetch), .rd_addr(rd_addr), .rd_data(rd_data),
    .flash_irq(flash_irq), .busy(busy));
  fppc_cpu_model i_cpu (.clk_sys(clk_sys), .rd_req(rd_req), .rd_fetch(rd_fetch),
    .rd_addr(rd_addr), .rd_data(rd_data));

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask
  task automatic achk(input logic f, input logic [16:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_cpu.access(f, a, d);
    chk("array word", d, exp);
  endtask
  // start an operation, check its bit, poll until it clears
  task automatic op(input logic [31:0] ctl, input logic started);
    logic [31:0] c;
    wr(A_CTL, ctl);
    rd(A_CTL, c);
    chk("op bits", {28'h0, c[3:0]}, {28'h0, started ? ctl[3:0] : 4'h0});
    chk("busy", {31'h0, busy}, {31'h0, started});
    for (int i = 0; i < 40000; i++) begin
      rd(A_CTL, c);
      if (c[3:0] === 4'h0) return;
    end
    errors++;
    test_done();
  endtask
  task automatic reset(input logic por);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    por_n <= ~por;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    errors++;
    test_done();
  end
  // main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    por_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rchk(fppc_pkg::OFS_USEC_RELOAD, {24'h0, fppc_pkg::USEC_RELOAD_RST}, "reload");
    rchk(A_PE, 32'hffff_ffff, "prog enable");
    rchk(A_RE, 32'hffff_ffff, "read enable");
    rchk(A_U0, 32'hffff_ffff, "user 0");
    rchk(A_DBG, 32'hffff_fffe, "debug");
    wr(12'h0fc, 32'h5555_5555);
    rchk(A_TGT, 32'h0, "target after unmapped write");
    wr(fppc_pkg::OFS_USEC_RELOAD, 32'h9);
    op(KEY | 32'h4, 1'b1);
    achk(1'b1, 17'h0, 32'hffff_ffff);
    wr(A_DAT, 32'h1234_5678);
    wr(A_TGT, 32'h800);
    op(KEY | 32'h1, 1'b1);
    wr(A_DAT, 32'hffff_00ff);
    op(KEY | 32'h1, 1'b1);
    achk(1'b0, 17'h800, 32'h1234_0078);
    wr(A_DAT, 32'h0);
    wr(A_TGT, 32'hc00);
    op(KEY | 32'h1, 1'b1);
    wr(A_TGT, 32'h800);
    op(KEY | 32'h2, 1'b1);
    achk(1'b0, 17'h800, 32'hffff_ffff);
    achk(1'b0, 17'h0bfc, 32'hffff_ffff);
    achk(1'b0, 17'h0c00, 32'h0);
    op(32'h0000_0001, 1'b0);
    wr(fppc_pkg::OFS_INT_MASK, 32'h1);
    wr(A_PE, 32'hffff_fffd);
    op(KEY | 32'h1, 1'b0);
    achk(1'b0, 17'h800, 32'hffff_ffff);
    #1 chk("violation irq", {31'h0, flash_irq}, 32'h1);
    rchk(fppc_pkg::OFS_INT_CLEAR, 32'h1, "masked status");
    wr(fppc_pkg::OFS_INT_CLEAR, 32'h1);
    #1 chk("irq cleared", {31'h0, flash_irq}, 32'h0);
    op(KEY | 32'h2, 1'b0);
    wr(A_RE, 32'hffff_fffd);
    achk(1'b0, 17'h800, 32'h0);
    achk(1'b1, 17'h800, 32'hffff_ffff);
    rd(fppc_pkg::OFS_RAW_STATUS, v);
    chk("read violation", {29'h0, v[2], 2'h0}, 32'h4);
    wr(A_TGT, 32'h1);
    op(KEY | 32'h8, 1'b1);
    wr(A_U0, 32'h7fff_ffff);
    wr(A_TGT, fppc_pkg::SEL_USER_0);
    op(KEY | 32'h8, 1'b1);
    wr(A_U0, 32'h3fff_ffff);
    rchk(A_U0, 32'h7fff_ffff, "user frozen");
    op(KEY | 32'h8, 1'b1);
    wr(A_DAT, 32'h7fff_fffe);
    wr(A_TGT, fppc_pkg::SEL_DEBUG);
    op(KEY | 32'h8, 1'b1);
    reset(1'b0);
    rchk(A_PE, 32'hffff_fffd, "committed");
    rchk(A_RE, 32'hffff_ffff, "uncommitted");
    rchk(A_U0, 32'h7fff_ffff, "user once");
    rchk(A_DBG, 32'h7fff_fffe, "debug commit");
    wr(fppc_pkg::OFS_USEC_RELOAD, 32'h9);
    wr(A_TGT, 32'h0);
    op(KEY | 32'h2, 1'b1);
    rchk(A_U0, 32'h7fff_ffff, "user after erase");
    reset(1'b1);
    rchk(A_PE, 32'hffff_ffff, "factory state");
    test_done();
  end
endmodule // tb_flash_program_protect_ctrl
